// File: src/gpib_pkg.sv
// Shared constants and carrier types for the instrument-side bus interface
package gpib_pkg;

	// Clock rate and derived timing
	localparam int unsigned CLK_MHZ    = 100;
	localparam int unsigned SETTLE_NS  = 20;
	localparam int unsigned SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0]  SETTLE_CNT = 4'(SETTLE_CYC);

	// Widths and buffer depth
	localparam int unsigned BYTE_W     = 8;
	localparam int unsigned ADDR_W     = 5;
	localparam int unsigned TX_DEPTH   = 8;

	// Multiline command layout: group in the upper bits, address in the low five
	localparam int unsigned GRP_LSB    = 5;
	localparam logic [1:0]  GRP_LISTEN = 2'h1;
	localparam logic [1:0]  GRP_TALK   = 2'h2;
	localparam logic [4:0]  ADDR_NONE  = 5'h1F;

	// Status word layout
	localparam int unsigned STAT_RQS   = 6;
	localparam int unsigned CAUSE_W    = 6;

	// Reset values
	localparam logic        RST_FLAG   = 1'b0;
	localparam logic [7:0]  RST_BYTE   = 8'h00;

	typedef enum logic [1:0] {
		S_IDLE  = 2'b00,
		S_LOAD  = 2'b01,
		S_VALID = 2'b11,
		S_REL   = 2'b10
	} src_state_e;

	typedef enum logic [1:0] {
		A_HOLD = 2'b00,
		A_RDY  = 2'b01,
		A_ACC  = 2'b11,
		A_REL  = 2'b10
	} acc_state_e;

	// Bus lines as seen inside: 1 means asserted (pin low)
	typedef struct packed {
		logic             atn;
		logic             ren;
		logic             ifc;
		logic             eoi;
		logic             dav;
		logic             nrfd;
		logic             ndac;
		logic [BYTE_W-1:0] dio;
	} bus_s;

	localparam bus_s BUS_IDLE = '0;

	typedef struct packed {
		logic              last;
		logic [BYTE_W-1:0] data;
	} tx_word_s;

	typedef struct packed {
		logic              cmd;
		logic              last;
		logic [BYTE_W-1:0] data;
	} rx_byte_s;

endpackage : gpib_pkg

// File: src/gpib_handshake_management.sv
// Talk buffer and instrument-side management and byte handshake logic
`timescale 1ns/100ps

// What this block does
// - All bus lines are asserted when low.
// - Byte under ATN is command, otherwise data.
// - REN prepares remote operation; own address lights remote indicator.
// - REN plus own address remotes only us.
// - IFC forces talk idle and listen idle.
// - IFC darkens talk/listen indicators, remote untouched.
// - IFC never cancels remote mode.
// - Source asserts EOI with final byte.
// - Pull SRQ low while service needed.
// - Status word shows service request cause.
// - Source drives DAV; acceptors drive NRFD, NDAC.
// - NRFD/NDAC wired-AND; slowest acceptor decides.
// - Byte placed, NRFD high, NDAC low before DAV.
// - Assert DAV once byte stable and ready.
// - Acceptor drops NRFD, then releases NDAC.
// - Source releases DAV after NDAC high.
// - Acceptor pulls NDAC low after DAV release.
// - Release NRFD when ready; repeat after high.
// - One byte per handshake, data or command.
// - Eight active-low data lines, one byte each.

module tx_fifo #(
	parameter int unsigned WIDTH = 9,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int unsigned PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wr_q;
	logic [PW-1:0]    rd_q;
	logic [PW:0]      cnt_q;
	logic [PW:0]      cnt_d;
	logic             push;
	logic             pop;

	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];

	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_q     <= '0;
			rd_q     <= '0;
			cnt_q    <= '0;
			in_ready <= 1'b0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q    <= cnt_d;
			in_ready <= (cnt_d != FULL_CNT);
		end
	end

	a_fifo_no_overrun: assert property (@(posedge ref_clk) disable iff (rst)
		cnt_q == FULL_CNT |-> !in_ready)
		else $error("fifo accepts while full");

endmodule : tx_fifo

module gpib_handshake_management import gpib_pkg::*; (
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] my_addr,
	input  wire logic              tx_valid,
	input  wire logic [BYTE_W-1:0] tx_data,
	input  wire logic              tx_last,
	output logic                   tx_ready,
	output logic                   rx_valid,
	output logic      [BYTE_W-1:0] rx_data,
	output logic                   rx_cmd,
	output logic                   rx_end,
	input  wire logic              rx_ready,
	input  wire logic [CAUSE_W-1:0] srq_cause,
	output logic      [BYTE_W-1:0] status_word,
	output logic                   remote_led,
	output logic                   talk_led,
	output logic                   listen_led,
	input  wire logic              atn_n,
	input  wire logic              ren_n,
	input  wire logic              ifc_n,
	input  wire logic              eoi_n_i,
	output logic                   eoi_n_o,
	output logic                   eoi_n_oe,
	input  wire logic              srq_n_i,
	output logic                   srq_n_o,
	output logic                   srq_n_oe,
	input  wire logic              dav_n_i,
	output logic                   dav_n_o,
	output logic                   dav_n_oe,
	input  wire logic              nrfd_n_i,
	output logic                   nrfd_n_o,
	output logic                   nrfd_n_oe,
	input  wire logic              ndac_n_i,
	output logic                   ndac_n_o,
	output logic                   ndac_n_oe,
	input  wire logic [BYTE_W-1:0] dio_n_i,
	output logic      [BYTE_W-1:0] dio_n_o,
	output logic                   dio_n_oe
);
	bus_s       raw;
	bus_s       meta_q;
	bus_s       bus;
	logic       pin_lvl_q;
	src_state_e src_q;
	acc_state_e acc_q;
	logic [3:0] settle_q;
	logic       last_q;
	logic       src_on;
	logic       acc_on;
	logic       capture;
	logic       pop;
	tx_word_s   push_word;
	tx_word_s   head_word;
	logic       head_valid;
	logic [1:0] grp;
	logic [4:0] cmd_addr;

	assign raw = bus_s'({~atn_n, ~ren_n, ~ifc_n, ~eoi_n_i, ~dav_n_i, ~nrfd_n_i,
		~ndac_n_i, ~dio_n_i});

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			meta_q <= BUS_IDLE;
			bus    <= BUS_IDLE;
		end else begin
			meta_q <= raw;
			bus    <= meta_q;
		end
	end

	// Open-drain lines only ever pull low; the level flop keeps outputs registered
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_lvl_q <= RST_FLAG;
		end else begin
			pin_lvl_q <= RST_FLAG;
		end
	end

	assign eoi_n_o  = pin_lvl_q;
	assign srq_n_o  = pin_lvl_q;
	assign dav_n_o  = pin_lvl_q;
	assign nrfd_n_o = pin_lvl_q;
	assign ndac_n_o = pin_lvl_q;

	// source pauses while controller holds ATN
	assign src_on = talk_led && !bus.atn;
	assign acc_on = bus.atn || listen_led;
	assign pop    = src_on && (src_q == S_IDLE) && head_valid;

	assign push_word = '{last: tx_last, data: tx_data};

	tx_fifo #(
		.WIDTH ($bits(tx_word_s)),
		.DEPTH (TX_DEPTH)
	) u_tx_fifo (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.in_data   (push_word),
		.out_valid (head_valid),
		.out_ready (pop),
		.out_data  (head_word)
	);

	// Source handshake; a byte under way is dropped if ATN takes the bus
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			src_q    <= S_IDLE;
			settle_q <= '0;
			last_q   <= RST_FLAG;
			dio_n_o  <= ~RST_BYTE;
			dio_n_oe <= RST_FLAG;
			eoi_n_oe <= RST_FLAG;
			dav_n_oe <= RST_FLAG;
		end else if (!src_on) begin
			src_q    <= S_IDLE;
			dio_n_oe <= 1'b0;
			eoi_n_oe <= 1'b0;
			dav_n_oe <= 1'b0;
		end else begin
			case (src_q)
				S_IDLE: begin
					if (head_valid) begin
						dio_n_o  <= ~head_word.data;
						dio_n_oe <= 1'b1;
						eoi_n_oe <= head_word.last;
						last_q   <= head_word.last;
						settle_q <= SETTLE_CNT;
						src_q    <= S_LOAD;
					end
				end
				S_LOAD: begin
					if (settle_q != '0) begin
						settle_q <= settle_q - 1'b1;
					end else if (!bus.nrfd && bus.ndac) begin
						dav_n_oe <= 1'b1;
						src_q    <= S_VALID;
					end
				end
				S_VALID: begin
					if (!bus.ndac) begin
						dav_n_oe <= 1'b0;
						src_q    <= S_REL;
					end
				end
				S_REL: begin
					if (bus.ndac) begin
						dio_n_oe <= 1'b0;
						eoi_n_oe <= 1'b0;
						src_q    <= S_IDLE;
					end
				end
				default: begin
					src_q <= S_IDLE;
				end
			endcase
		end
	end

	assign capture = acc_on && (acc_q == A_RDY) && bus.dav;

	// Acceptor handshake; a bystander releases both lines
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			acc_q     <= A_HOLD;
			nrfd_n_oe <= RST_FLAG;
			ndac_n_oe <= RST_FLAG;
		end else if (!acc_on) begin
			acc_q     <= A_HOLD;
			nrfd_n_oe <= 1'b0;
			ndac_n_oe <= 1'b0;
		end else begin
			case (acc_q)
				A_HOLD: begin
					nrfd_n_oe <= 1'b1;
					ndac_n_oe <= 1'b1;
					if (rx_ready && !bus.dav) begin
						nrfd_n_oe <= 1'b0;
						acc_q     <= A_RDY;
					end
				end
				A_RDY: begin
					if (bus.dav) begin
						nrfd_n_oe <= 1'b1;
						acc_q     <= A_ACC;
					end
				end
				A_ACC: begin
					ndac_n_oe <= 1'b0;
					acc_q     <= A_REL;
				end
				A_REL: begin
					if (!bus.dav) begin
						ndac_n_oe <= 1'b1;
						acc_q     <= A_HOLD;
					end
				end
				default: begin
					acc_q <= A_HOLD;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rx_valid <= RST_FLAG;
			rx_data  <= RST_BYTE;
			rx_cmd   <= RST_FLAG;
			rx_end   <= RST_FLAG;
		end else begin
			rx_valid <= capture;
			if (capture) begin
				rx_data <= bus.dio;
				rx_cmd  <= bus.atn;
				rx_end  <= bus.eoi && !bus.atn;
			end
		end
	end

	assign grp      = bus.dio[GRP_LSB+1:GRP_LSB];
	assign cmd_addr = bus.dio[GRP_LSB-1:0];

	// Addressing; a talker is never also a listener here
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			talk_led   <= RST_FLAG;
			listen_led <= RST_FLAG;
		end else if (bus.ifc) begin
			talk_led   <= 1'b0;
			listen_led <= 1'b0;
		end else if (capture && bus.atn) begin
			if (grp == GRP_LISTEN) begin
				if (cmd_addr == ADDR_NONE) begin
					listen_led <= 1'b0;
				end else if (cmd_addr == my_addr) begin
					listen_led <= 1'b1;
					talk_led   <= 1'b0;
				end
			end else if (grp == GRP_TALK) begin
				talk_led <= (cmd_addr == my_addr);
				if (cmd_addr == my_addr) begin
					listen_led <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			remote_led <= RST_FLAG;
		end else if (!bus.ren) begin
			remote_led <= 1'b0;
		end else if (capture && bus.atn && cmd_addr == my_addr &&
			(grp == GRP_LISTEN || grp == GRP_TALK)) begin
			remote_led <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			srq_n_oe    <= RST_FLAG;
			status_word <= RST_BYTE;
		end else begin
			srq_n_oe                   <= (srq_cause != '0);
			status_word                <= RST_BYTE;
			status_word[STAT_RQS]      <= (srq_cause != '0);
			status_word[CAUSE_W-1:0]   <= srq_cause;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_gap2;
		!rx_valid ##1 !rx_valid;
	endsequence

	a_dav_needs_ready: assert property (
		$rose(dav_n_oe) |-> $past(!bus.nrfd && bus.ndac) && dio_n_oe)
		else $error("DAV asserted before acceptors ready");

	a_dav_byte_stable: assert property (
		dav_n_oe && $past(dav_n_oe) |-> $stable(dio_n_o) && dio_n_oe)
		else $error("data changed while DAV asserted");

	a_dav_release: assert property (
		src_q == S_VALID && src_on && !bus.ndac |=> !dav_n_oe ##1 !dav_n_oe)
		else $error("DAV not released after NDAC high");

	a_eoi_with_last: assert property (
		$rose(dav_n_oe) |-> eoi_n_oe == last_q)
		else $error("EOI does not match final byte");

	a_nrfd_then_ndac: assert property (
		$fell(ndac_n_oe) && acc_on |-> nrfd_n_oe && $past(nrfd_n_oe))
		else $error("NDAC released before NRFD pulled low");

	a_ndac_relow: assert property (
		acc_q == A_REL && acc_on && !bus.dav |=> ndac_n_oe)
		else $error("NDAC not pulled low after DAV release");

	a_one_byte: assert property (
		rx_valid |=> s_gap2)
		else $error("two bytes taken in one handshake");

	a_cmd_flag: assert property (
		rx_valid |-> rx_cmd == $past(bus.atn))
		else $error("command flag does not follow ATN");

	a_ifc_clears: assert property (
		bus.ifc |=> !talk_led && !listen_led)
		else $error("IFC left talker or listener active");

	a_ifc_keeps_remote: assert property (
		bus.ifc && bus.ren |=> remote_led == $past(remote_led))
		else $error("IFC changed remote state");

	a_remote_needs_ren: assert property (
		$rose(remote_led) |-> $past(bus.ren) && $past(capture))
		else $error("remote entered without REN and address");

	a_srq_drive: assert property (
		srq_cause != '0 |=> srq_n_oe && status_word[STAT_RQS])
		else $error("SRQ not pulled for pending cause");

endmodule : gpib_handshake_management

// File: testbench/bus_ctrl_model.sv
// Controller and peer instrument on the far side of the bus
`timescale 1ns/100ps
module bus_ctrl_model (
	input  wire logic       ref_clk,
	input  wire logic       eoi_oe,
	input  wire logic       srq_oe,
	input  wire logic       dav_oe,
	input  wire logic       nrfd_oe,
	input  wire logic       ndac_oe,
	input  wire logic       dio_oe,
	input  wire logic [7:0] dio_o,
	output logic            atn_n,
	output logic            ren_n,
	output logic            ifc_n,
	output logic            eoi_n,
	output logic            srq_n,
	output logic            dav_n,
	output logic            nrfd_n,
	output logic            ndac_n,
	output logic      [7:0] dio_n,
	output int              faults
);
	// Each m_ flag high means this side pulls the line low
	logic       m_eoi, m_dav, m_nrfd, m_ndac;
	logic [7:0] m_dio;

	// pulled-up lines, any party low wins
	assign eoi_n  = ~(eoi_oe | m_eoi);
	assign srq_n  = ~srq_oe;
	assign dav_n  = ~(dav_oe | m_dav);
	assign nrfd_n = ~(nrfd_oe | m_nrfd);
	assign ndac_n = ~(ndac_oe | m_ndac);
	assign dio_n  = (dio_oe ? dio_o : 8'hFF) & ~m_dio;

	initial begin
		{atn_n, ren_n, ifc_n} = 3'h7;
		{m_eoi, m_dav, m_dio} = '0;
		// Idle acceptor is never ready, so a talker must wait
		{m_nrfd, m_ndac} = 2'h3;
		faults = 0;
	end

	function automatic logic lvl(input int k);
		case (k)
			0: return dav_n;
			1: return nrfd_n;
			default: return ndac_n;
		endcase
	endfunction : lvl

	task automatic wait_lvl(input int k, input logic v);
		int n;
		n = 0;
		while (lvl(k) !== v && n < 200) begin
			@(posedge ref_clk);
			n++;
		end
		if (lvl(k) !== v) faults++;
	endtask : wait_lvl

	task automatic mgmt(input logic atn, input logic ren, input logic ifc);
		@(posedge ref_clk);
		atn_n <= ~atn;
		ren_n <= ~ren;
		ifc_n <= ~ifc;
	endtask : mgmt

	task automatic send_byte(input logic [7:0] d, input logic last);
		@(posedge ref_clk);
		{m_nrfd, m_ndac} <= 2'h0;
		m_dio <= d;
		// end marker rides with the final byte
		m_eoi <= last;
		// byte placed, acceptor ready, not yet done
		wait_lvl(1, 1'b1);
		wait_lvl(2, 1'b0);
		@(posedge ref_clk);
		m_dav <= 1'b1;
		wait_lvl(2, 1'b1);
		if (nrfd_n !== 1'b0) faults++;
		m_dav <= 1'b0;
		{m_dio, m_eoi} <= '0;
		wait_lvl(2, 1'b0);
	endtask : send_byte

	task automatic accept_byte(input int dly, output logic [7:0] d, output logic e);
		@(posedge ref_clk);
		{m_nrfd, m_ndac} <= 2'h3;
		// no valid byte while not ready
		repeat (dly) begin
			@(posedge ref_clk);
			if (dav_n !== 1'b1) faults++;
		end
		m_nrfd <= 1'b0;
		wait_lvl(0, 1'b0);
		d = ~dio_n;
		e = ~eoi_n;
		// busy first, byte taken after a delay
		m_nrfd <= 1'b1;
		// talker holds the byte until taken
		repeat (dly) begin
			@(posedge ref_clk);
			if (dav_n !== 1'b0) faults++;
		end
		m_ndac <= 1'b0;
		wait_lvl(0, 1'b1);
		m_ndac <= 1'b1;
	endtask : accept_byte
endmodule : bus_ctrl_model

// File: testbench/gpib_handshake_management_tb.sv
// Self-checking bench for the instrument-side bus interface
`timescale 1ns/100ps
module gpib_handshake_management_tb import gpib_pkg::*; ();
	logic               ref_clk, rst, tx_valid, tx_last, rx_ready;
	logic [ADDR_W-1:0]  my_addr;
	logic [BYTE_W-1:0]  tx_data, rx_data, status_word, dio_n, dio_o;
	logic [CAUSE_W-1:0] srq_cause;
	logic               tx_ready, rx_valid, rx_cmd, rx_end;
	logic               remote_led, talk_led, listen_led;
	logic               atn_n, ren_n, ifc_n, eoi_n, srq_n, dav_n, nrfd_n, ndac_n;
	logic               eoi_oe, srq_oe, dav_oe, nrfd_oe, ndac_oe, dio_oe;
	logic [4:0]         pin_o;
	int                 err_total, check_count, faults;
	logic [9:0]         rxq[$];

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	gpib_handshake_management i_dut (
		.ref_clk(ref_clk), .rst(rst), .my_addr(my_addr),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_cmd(rx_cmd), .rx_end(rx_end),
		.rx_ready(rx_ready), .srq_cause(srq_cause), .status_word(status_word),
		.remote_led(remote_led), .talk_led(talk_led), .listen_led(listen_led),
		.atn_n(atn_n), .ren_n(ren_n), .ifc_n(ifc_n),
		.eoi_n_i(eoi_n), .eoi_n_o(pin_o[4]), .eoi_n_oe(eoi_oe),
		.srq_n_i(srq_n), .srq_n_o(pin_o[3]), .srq_n_oe(srq_oe),
		.dav_n_i(dav_n), .dav_n_o(pin_o[2]), .dav_n_oe(dav_oe),
		.nrfd_n_i(nrfd_n), .nrfd_n_o(pin_o[1]), .nrfd_n_oe(nrfd_oe),
		.ndac_n_i(ndac_n), .ndac_n_o(pin_o[0]), .ndac_n_oe(ndac_oe),
		.dio_n_i(dio_n), .dio_n_o(dio_o), .dio_n_oe(dio_oe)
	);

	bus_ctrl_model i_ctrl (
		.ref_clk(ref_clk), .eoi_oe(eoi_oe), .srq_oe(srq_oe), .dav_oe(dav_oe),
		.nrfd_oe(nrfd_oe), .ndac_oe(ndac_oe), .dio_oe(dio_oe), .dio_o(dio_o),
		.atn_n(atn_n), .ren_n(ren_n), .ifc_n(ifc_n), .eoi_n(eoi_n), .srq_n(srq_n),
		.dav_n(dav_n), .nrfd_n(nrfd_n), .ndac_n(ndac_n), .dio_n(dio_n), .faults(faults)
	);

	always @(posedge ref_clk) begin
		if (rx_valid === 1'b1) rxq.push_back({rx_cmd, rx_end, rx_data});
	end

	task automatic stop_test;
		if (err_total == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic rx_chk(input logic [9:0] exp);
		logic [9:0] v;
		v = 10'h3FF;
		if (rxq.size() > 0) v = rxq.pop_front();
		chk("rx byte", 16'(exp), 16'(v));
	endtask : rx_chk

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : idle

	task automatic t_reset;
		// Idle peer acceptor holds NRFD and NDAC low
		chk("idle lines", 16'h04FF, 16'({dav_n, nrfd_n, ndac_n, dio_n}));
		chk("drive idle", 16'h00FF, 16'({eoi_oe, srq_oe, dav_oe, nrfd_oe, ndac_oe, dio_oe, dio_o}));
		chk("pin levels", 16'h0, 16'(pin_o));
		chk("leds status", 16'h0, 16'({remote_led, talk_led, listen_led, status_word}));
		chk("tx_ready", 16'h1, 16'(tx_ready));
	endtask : t_reset

	task automatic t_address;
		@(posedge ref_clk);
		rx_ready <= 1'b0;
		i_ctrl.mgmt(1'b1, 1'b1, 1'b0);
		idle(6);
		fork
			i_ctrl.send_byte(8'h2B, 1'b0);
			begin
				repeat (20) begin
					@(negedge ref_clk);
					chk("stall nrfd", 16'h0, 16'(nrfd_n));
				end
				@(posedge ref_clk);
				rx_ready <= 1'b1;
			end
		join
		idle(2);
		rx_chk(10'h22B);
		chk("other addr", 16'h0, 16'({remote_led, listen_led}));
		i_ctrl.send_byte(8'h2A, 1'b0);
		idle(2);
		rx_chk(10'h22A);
		chk("own addr", 16'h3, 16'({remote_led, listen_led}));
	endtask : t_address

	task automatic t_data;
		logic [7:0] tbl [3] = '{8'hA5, 8'h5A, 8'h00};
		i_ctrl.mgmt(1'b0, 1'b1, 1'b0);
		idle(4);
		for (int i = 0; i < 3; i++) begin
			i_ctrl.send_byte(tbl[i], i == 2);
			rx_chk({1'b0, i == 2, tbl[i]});
		end
		i_ctrl.mgmt(1'b1, 1'b1, 1'b0);
		idle(4);
		i_ctrl.send_byte(8'h3F, 1'b0);
		rx_chk(10'h23F);
		chk("unlisten", 16'h0, 16'(listen_led));
	endtask : t_data

	task automatic t_talk;
		logic [7:0] d;
		logic       e;
		i_ctrl.mgmt(1'b1, 1'b1, 1'b0);
		idle(4);
		i_ctrl.send_byte(8'h4A, 1'b0);
		rx_chk(10'h24A);
		chk("talk listen", 16'h2, 16'({talk_led, listen_led}));
		// Fill while attention holds the talker back; the ninth word is refused
		for (int i = 0; i < 9; i++) begin
			@(posedge ref_clk);
			tx_valid <= 1'b1;
			tx_data <= 8'h30 + 8'(i);
			tx_last <= (i == 7);
			@(negedge ref_clk);
			chk("tx_ready", 16'(i < 8), 16'(tx_ready));
		end
		@(posedge ref_clk);
		tx_valid <= 1'b0;
		i_ctrl.mgmt(1'b0, 1'b1, 1'b0);
		for (int i = 0; i < 8; i++) begin
			i_ctrl.accept_byte(i % 2 ? 5 : 1, d, e);
			chk("talk byte", 16'h30 + 16'(i), 16'(d));
			chk("talk end", 16'(i == 7), 16'(e));
		end
		idle(6);
		chk("released", 16'h1FF, 16'({tx_ready, dio_n}));
	endtask : t_talk

	task automatic t_ifc;
		i_ctrl.mgmt(1'b0, 1'b1, 1'b1);
		idle(6);
		chk("ifc leds", 16'h4, 16'({remote_led, talk_led, listen_led}));
		i_ctrl.mgmt(1'b0, 1'b0, 1'b0);
		idle(4);
		chk("ren off", 16'h0, 16'(remote_led));
	endtask : t_ifc

	task automatic t_srq;
		@(posedge ref_clk);
		srq_cause <= 6'h15;
		idle(3);
		chk("srq on", 16'h055, 16'({srq_n, status_word}));
		@(posedge ref_clk);
		srq_cause <= 6'h00;
		idle(3);
		chk("srq off", 16'h100, 16'({srq_n, status_word}));
	endtask : t_srq

	initial begin
		rst = 1'b1;
		my_addr = 5'h0A;
		{tx_valid, tx_last, tx_data} = '0;
		rx_ready = 1'b1;
		srq_cause = '0;
		err_total = 0;
		check_count = 0;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		idle(2);
		t_reset();
		t_address();
		t_data();
		t_talk();
		t_ifc();
		t_srq();
		chk("bus faults", 16'h0, 16'(faults));
		stop_test();
	end

	initial begin
		repeat (50000) @(posedge ref_clk);
		err_total++;
		stop_test();
	end
endmodule : gpib_handshake_management_tb
